// ### logic/lin_uart_regs.vh
// register map, field positions and timing constants of the lin/uart sequencer
`ifndef LIN_UART_REGS_VH
`define LIN_UART_REGS_VH
`define A_CTRL 3'h0
`define A_STAT 3'h1
`define A_ERR 3'h2
`define A_ID 3'h3
`define A_LEN 3'h4
`define A_SEL 3'h5
`define A_DAT 3'h6
`define C_EN 3
`define C_LEG 4
`define F_RXD 0
`define F_TXD 1
`define F_IDOK 2
`define E_PAR 0
`define E_CRC 1
`define E_FRAMING_ERROR_FLAG 2
`define E_TOUT 3
`define E_OVR 4
`define E_ABT 5
`define CMD_IDLE 2'h0
`define CMD_THDR 2'h1
`define CMD_RRSP 2'h2
`define CMD_TRSP 2'h3
`define SYNC_CHAR 8'h55
`define CKS_GOOD 8'hFF
`define BREAK_FRAME 14'h2000
`define BREAK_BITS 4'hE
`define BYTE_BITS 4'hA
`define ID_CLASSIC 6'h3C
`define MAX_LEN 4'h8
`define CLK_HZ 100000000
`define BAUD_RATE 19200
`define TOUT_BITS 175
`endif

// ### logic/lin_uart_command_sequencer.v
// lin/uart command sequencer with register port and serial line
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_regs.vh"
module lin_uart_command_sequencer #(
   parameter BIT_CYCLES = `CLK_HZ / `BAUD_RATE,
   parameter TOUT_CYCLES = BIT_CYCLES * `TOUT_BITS
) (
   input wire mclk,
   input wire arst_n,
   input wire [2:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [7:0] rdata,
   input wire rx_pin,
   output reg tx_pin
);
   localparam Q_IDLE = 3'h0;
   localparam Q_BRK = 3'h1;
   localparam Q_SYN = 3'h2;
   localparam Q_PID = 3'h3;
   localparam Q_RRX = 3'h4;
   localparam Q_RTX = 3'h5;
   localparam Q_CKS = 3'h6;
   localparam R_IDLE = 3'h0;
   localparam R_START = 3'h1;
   localparam R_DATA = 3'h2;
   localparam R_STOP = 3'h3;
   localparam R_WAIT = 3'h4;
   localparam H_NONE = 2'h0;
   localparam H_SYNC = 2'h1;
   localparam H_PID = 2'h2;

   reg en_reg, leg_reg;
   reg [2:0] cmd_reg;
   reg rxd_reg, txd_reg, idok_reg;
   reg [5:0] err_reg;
   reg [5:0] id_reg;
   reg [3:0] rxl_reg, txl_reg;
   reg [2:0] sel_reg;
   reg [7:0] hold_reg;
   reg [7:0] buf_mem [0:7];
   reg rx_s1, rx_s2;
   reg [2:0] rx_st;
   reg [31:0] rx_cnt;
   reg [2:0] rx_bit;
   reg [7:0] rx_sh;
   reg rx_vld, rx_framing_error_flag;
   reg [13:0] tx_sh;
   reg [3:0] tx_n;
   reg [31:0] tx_cnt;
   reg tx_act;
   reg [2:0] sq;
   reg [3:0] rsp_n, rsp_len;
   reg [7:0] ck;
   reg [1:0] hp;
   reg [31:0] to_cnt;
   reg to_run;

   // protected identifier: parity bits above the six id bits
   function [7:0] pid;
      input [5:0] i;
      begin
         pid = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
      end
   endfunction

   // add with carry wrap-around
   function [7:0] cks;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         cks = s[7:0] + {7'h00, s[8]};
      end
   endfunction

   function [3:0] lenlim;
      input [3:0] l;
      begin
         lenlim = (l > `MAX_LEN) ? `MAX_LEN : l;
      end
   endfunction

   // legacy length from identifier bits 5..4
   function [3:0] legl;
      input [5:0] i;
      begin
         legl = i[5] ? (i[4] ? 4'h8 : 4'h4) : 4'h2;
      end
   endfunction

   function [13:0] frame;
      input [7:0] d;
      begin
         frame = {4'hF, 1'b1, d, 1'b0};
      end
   endfunction

   wire lin = en_reg & ~cmd_reg[2];
   wire uart = en_reg & cmd_reg[2];
   wire busy = (sq != Q_IDLE) | tx_act;
   wire bit_end = (tx_cnt == BIT_CYCLES - 1);
   wire tx_end = tx_act & bit_end & (tx_n == 4'h1);
   wire [7:0] rx_byte = rx_sh;
   wire brk = rx_vld & rx_framing_error_flag & (rx_byte == 8'h00);
   wire in_rsp = (sq == Q_RRX) | (sq == Q_RTX) | (sq == Q_CKS);
   wire hdr_tx = (sq == Q_BRK) | (sq == Q_SYN) | (sq == Q_PID);
   wire classic = leg_reg | (id_reg >= `ID_CLASSIC);
   wire ctrl_wr = wr_en & (addr == `A_CTRL);

   task start_tx;
      input [13:0] sh;
      input [3:0] n;
      begin
         tx_sh <= sh;
         tx_n <= n;
         tx_cnt <= 32'h0000_0000;
         tx_act <= 1'b1;
         tx_pin <= sh[0];
      end
   endtask

   // input synchroniser
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= rx_pin;
         rx_s2 <= rx_s1;
      end
   end

   // byte receiver, mid-bit sampling; a low stop bit waits for idle line
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_st <= R_IDLE;
         rx_cnt <= 32'h0000_0000;
         rx_bit <= 3'h0;
         rx_sh <= 8'h00;
         rx_vld <= 1'b0;
         rx_framing_error_flag <= 1'b0;
      end else begin
         rx_vld <= 1'b0;
         rx_cnt <= rx_cnt + 32'h0000_0001;
         if (!en_reg) begin
            rx_st <= R_IDLE;
         end else begin
            case (rx_st)
               R_IDLE: begin
                  rx_cnt <= 32'h0000_0000;
                  if (!rx_s2) begin
                     rx_st <= R_START;
                  end
               end
               R_START: begin
                  if (rx_cnt == BIT_CYCLES / 2) begin
                     rx_cnt <= 32'h0000_0000;
                     rx_bit <= 3'h0;
                     rx_st <= rx_s2 ? R_IDLE : R_DATA;
                  end
               end
               R_DATA: begin
                  if (rx_cnt == BIT_CYCLES - 1) begin
                     rx_cnt <= 32'h0000_0000;
                     rx_sh <= {rx_s2, rx_sh[7:1]};
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == 3'h7) begin
                        rx_st <= R_STOP;
                     end
                  end
               end
               R_STOP: begin
                  if (rx_cnt == BIT_CYCLES - 1) begin
                     rx_vld <= 1'b1;
                     rx_framing_error_flag <= ~rx_s2;
                     rx_st <= rx_s2 ? R_IDLE : R_WAIT;
                  end
               end
               R_WAIT: begin
                  if (rx_s2) begin
                     rx_st <= R_IDLE;
                  end
               end
               default: rx_st <= R_IDLE;
            endcase
         end
      end
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         en_reg <= 1'b0;
         leg_reg <= 1'b0;
         cmd_reg <= 3'h0;
         rxd_reg <= 1'b0;
         txd_reg <= 1'b0;
         idok_reg <= 1'b0;
         err_reg <= 6'h00;
         id_reg <= 6'h00;
         rxl_reg <= 4'h0;
         txl_reg <= 4'h0;
         sel_reg <= 3'h0;
         hold_reg <= 8'h00;
         rdata <= 8'h00;
         tx_pin <= 1'b1;
         tx_sh <= 14'h0000;
         tx_n <= 4'h0;
         tx_cnt <= 32'h0000_0000;
         tx_act <= 1'b0;
         sq <= Q_IDLE;
         rsp_n <= 4'h0;
         rsp_len <= 4'h0;
         ck <= 8'h00;
         hp <= H_NONE;
         to_cnt <= 32'h0000_0000;
         to_run <= 1'b0;
      end else begin
         // software reads and clears first, so hardware sets below win
         if (rd_en) begin
            case (addr)
               `A_CTRL: rdata <= {3'h0, leg_reg, en_reg, cmd_reg};
               `A_STAT: rdata <= {3'h0, busy, |err_reg, idok_reg, txd_reg, rxd_reg};
               `A_ERR: rdata <= {2'h0, err_reg};
               `A_ID: rdata <= pid(id_reg);
               `A_LEN: rdata <= uart ? 8'h00 : {txl_reg, rxl_reg};
               `A_SEL: rdata <= {5'h00, sel_reg};
               `A_DAT: begin
                  if (uart) begin
                     rdata <= hold_reg;
                     rxd_reg <= 1'b0;
                  end else begin
                     rdata <= buf_mem[sel_reg];
                     sel_reg <= sel_reg + 3'h1;
                  end
               end
               default: rdata <= 8'h00;
            endcase
         end
         if (wr_en) begin
            case (addr)
               `A_STAT: begin
                  rxd_reg <= rxd_reg & ~wdata[`F_RXD];
                  txd_reg <= txd_reg & ~wdata[`F_TXD];
                  idok_reg <= idok_reg & ~wdata[`F_IDOK];
               end
               `A_ERR: err_reg <= err_reg & ~wdata[5:0];
               `A_ID: if (!busy) id_reg <= wdata[5:0];
               `A_LEN: begin
                  if (!busy && !uart) begin
                     rxl_reg <= wdata[3:0];
                     txl_reg <= wdata[7:4];
                  end
               end
               `A_SEL: if (!uart) sel_reg <= wdata[2:0];
               `A_DAT: begin
                  if (uart) begin
                     if (cmd_reg[0] && !tx_act) begin
                        txd_reg <= 1'b0;
                        start_tx(frame(wdata), `BYTE_BITS);
                     end
                  end else if (!busy) begin
                     buf_mem[sel_reg] <= wdata;
                     sel_reg <= sel_reg + 3'h1;
                  end
               end
               default: ;
            endcase
         end

         // serial transmitter
         if (tx_act) begin
            tx_cnt <= tx_cnt + 32'h0000_0001;
            if (bit_end) begin
               tx_cnt <= 32'h0000_0000;
               tx_sh <= {1'b1, tx_sh[13:1]};
               tx_n <= tx_n - 4'h1;
               tx_pin <= (tx_n == 4'h1) ? 1'b1 : tx_sh[1];
               if (tx_n == 4'h1) begin
                  tx_act <= 1'b0;
               end
            end
         end
         if (to_run) begin
            to_cnt <= to_cnt + 32'h0000_0001;
         end

         if (uart) begin
            if (rx_vld && cmd_reg[1]) begin
               hold_reg <= rx_byte;
               rxd_reg <= 1'b1;
               if (rxd_reg) begin
                  err_reg[`E_OVR] <= 1'b1;
               end
               if (rx_framing_error_flag) begin
                  err_reg[`E_FRAMING_ERROR_FLAG] <= 1'b1;
               end
            end
            if (tx_end) begin
               txd_reg <= 1'b1;
            end
         end

         if (lin) begin
            case (sq)
               Q_IDLE: begin
                  if (!tx_act) begin
                     case (cmd_reg[1:0])
                        `CMD_THDR: begin
                           start_tx(`BREAK_FRAME, `BREAK_BITS);
                           sq <= Q_BRK;
                           to_cnt <= 32'h0000_0000;
                           to_run <= 1'b1;
                        end
                        `CMD_RRSP, `CMD_TRSP: begin
                           ck <= classic ? 8'h00 : pid(id_reg);
                           rsp_n <= 4'h0;
                           if (cmd_reg[0]) begin
                              rsp_len <= lenlim(txl_reg);
                              sq <= Q_RTX;
                           end else begin
                              rsp_len <= lenlim(rxl_reg);
                              sq <= Q_RRX;
                           end
                        end
                        default: ;
                     endcase
                  end
               end
               Q_BRK: begin
                  if (tx_end) begin
                     start_tx(frame(`SYNC_CHAR), `BYTE_BITS);
                     sq <= Q_SYN;
                  end
               end
               Q_SYN: begin
                  if (tx_end) begin
                     start_tx(frame(pid(id_reg)), `BYTE_BITS);
                     sq <= Q_PID;
                  end
               end
               Q_PID: begin
                  if (tx_end) begin
                     idok_reg <= 1'b1;
                     cmd_reg[1:0] <= `CMD_IDLE;
                     sq <= Q_IDLE;
                     if (leg_reg) begin
                        rxl_reg <= legl(id_reg);
                        txl_reg <= legl(id_reg);
                     end
                  end
               end
               Q_RTX: begin
                  if (!tx_act) begin
                     if (rsp_n == rsp_len) begin
                        start_tx(frame(~ck), `BYTE_BITS);
                        sq <= Q_CKS;
                     end else begin
                        start_tx(frame(buf_mem[rsp_n[2:0]]), `BYTE_BITS);
                        ck <= cks(ck, buf_mem[rsp_n[2:0]]);
                        rsp_n <= rsp_n + 4'h1;
                     end
                  end
               end
               Q_CKS: begin
                  if (tx_end) begin
                     txd_reg <= 1'b1;
                     cmd_reg[1:0] <= `CMD_IDLE;
                     to_run <= 1'b0;
                     sq <= Q_IDLE;
                  end
               end
               Q_RRX: begin
                  if (rx_vld && !brk && hp == H_NONE) begin
                     if (rx_framing_error_flag) begin
                        err_reg[`E_FRAMING_ERROR_FLAG] <= 1'b1;
                        cmd_reg[1:0] <= `CMD_IDLE;
                        sq <= Q_IDLE;
                     end else if (rsp_n == rsp_len) begin
                        if (cks(ck, rx_byte) != `CKS_GOOD) begin
                           err_reg[`E_CRC] <= 1'b1;
                        end else begin
                           rxd_reg <= 1'b1;
                        end
                        cmd_reg[1:0] <= `CMD_IDLE;
                        to_run <= 1'b0;
                        sq <= Q_IDLE;
                     end else begin
                        buf_mem[rsp_n[2:0]] <= rx_byte;
                        ck <= cks(ck, rx_byte);
                        rsp_n <= rsp_n + 4'h1;
                     end
                  end
               end
               default: sq <= Q_IDLE;
            endcase

            if (to_run && to_cnt == TOUT_CYCLES - 1) begin
               to_run <= 1'b0;
               if (in_rsp) begin
                  err_reg[`E_TOUT] <= 1'b1;
                  cmd_reg[1:0] <= `CMD_IDLE;
                  sq <= Q_IDLE;
                  tx_act <= 1'b0;
                  tx_pin <= 1'b1;
               end
            end

            if (rx_vld && !hdr_tx) begin
               if (brk) begin
                  hp <= H_SYNC;
                  to_cnt <= 32'h0000_0000;
                  to_run <= 1'b1;
                  if (sq == Q_RRX) begin
                     cmd_reg[1:0] <= `CMD_IDLE;
                     sq <= Q_IDLE;
                  end
               end else if (hp == H_SYNC) begin
                  hp <= (!rx_framing_error_flag && rx_byte == `SYNC_CHAR) ? H_PID : H_NONE;
               end else if (hp == H_PID) begin
                  hp <= H_NONE;
                  id_reg <= rx_byte[5:0];
                  idok_reg <= 1'b1;
                  if (rx_framing_error_flag || pid(rx_byte[5:0]) != rx_byte) begin
                     err_reg[`E_PAR] <= 1'b1;
                  end
                  if (leg_reg) begin
                     rxl_reg <= legl(rx_byte[5:0]);
                     txl_reg <= legl(rx_byte[5:0]);
                  end
               end
            end
         end

         // control write last: kill or abort overrides the engine
         if (ctrl_wr) begin
            en_reg <= wdata[`C_EN];
            leg_reg <= wdata[`C_LEG];
            cmd_reg <= wdata[2:0];
            if (!wdata[`C_EN] || wdata[2] != cmd_reg[2]) begin
               sq <= Q_IDLE;
               hp <= H_NONE;
               to_run <= 1'b0;
               tx_act <= 1'b0;
               tx_pin <= 1'b1;
            end else if (lin && sq != Q_IDLE && wdata[1:0] == `CMD_IDLE) begin
               err_reg[`E_ABT] <= 1'b1;
               sq <= Q_IDLE;
               to_run <= 1'b0;
               tx_act <= 1'b0;
               tx_pin <= 1'b1;
            end
         end
      end
   end
endmodule // lin_uart_command_sequencer
`default_nettype wire

// ### testbench/lin_uart_command_sequencer_sva.sv
// assertion checker on the ports of the lin/uart command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_regs.vh"
module sequencer_checker #(
   parameter BIT_CYCLES = 16
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rdata,
   input wire logic rx_pin,
   input wire logic tx_pin
);
   reg en_m;
   reg ua_m;
   reg [1:0] cmd_m;
   reg [15:0] lo_n;
   reg [15:0] hi_n;
   wire cw = wr_en && addr == `A_CTRL;
   // mode as last written, and run lengths of the serial output
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         {en_m, ua_m, cmd_m} <= 4'h0;
         lo_n <= 16'h0000;
         hi_n <= 16'h0000;
      end else begin
         if (cw) begin
            {ua_m, cmd_m} <= wdata[2:0];
            en_m <= wdata[`C_EN];
         end
         lo_n <= tx_pin ? 16'h0000 : lo_n + 16'h0001;
         hi_n <= !tx_pin ? 16'h0000 : (&hi_n ? hi_n : hi_n + 16'h0001);
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   chk_reset_tx_high: assert property ($rose(arst_n) |-> tx_pin)
      else $error("serial output low after reset");
   chk_unmapped_zero: assert property (rd_en && addr == 3'h7 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_disable_quiet: assert property (cw && !wdata[`C_EN] |-> ##2 tx_pin [*8])
      else $error("serial output active after disable");
   chk_header_starts: assert property (
      cw && wdata[3:0] == 4'h9 && hi_n > 2 * BIT_CYCLES |-> ##[1:2] !tx_pin [*8])
      else $error("header break did not start");
   chk_break_bits: assert property (
      $rose(tx_pin) |-> lo_n % BIT_CYCLES == 0 && lo_n <= 13 * BIT_CYCLES)
      else $error("low run not whole bits or longer than break");
   chk_uart_len_zero: assert property (
      rd_en && addr == `A_LEN && en_m && ua_m |=> rdata == 8'h00)
      else $error("length not zero in uart mode");
   chk_uart_tx_start: assert property (
      wr_en && addr == `A_DAT && en_m && ua_m && cmd_m[0] && hi_n > 2 * BIT_CYCLES |-> ##[1:2] !tx_pin)
      else $error("uart data write did not start a byte");
   chk_rx_only_quiet: assert property (
      en_m && ua_m && cmd_m == `CMD_RRSP && $past(tx_pin) |-> tx_pin)
      else $error("serial output active in receive only mode");
   cover property (cw && wdata[3:0] == 4'h9);
   cover property ($rose(tx_pin) && lo_n == 13 * BIT_CYCLES);
   cover property (wr_en && addr == `A_DAT && ua_m);
endmodule // sequencer_checker
`default_nettype wire

// ### testbench/lin_peer.sv
// serial peer: sends frames on the receive line, decodes the transmit line
`timescale 1ns/100ps
`default_nettype none
module lin_peer #(
   parameter BIT_CYCLES = 16
) (
   input wire logic mclk,
   input wire logic line_in,
   output var logic line_out
);
   logic [7:0] got[$];
   logic [7:0] b;
   initial line_out = 1'b1;
   task automatic send(input logic [7:0] v, input logic stop);
      logic [9:0] f;
      f = {stop, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk);
         line_out <= f[i];
         repeat (BIT_CYCLES - 1) @(posedge mclk);
      end
      @(posedge mclk);
      line_out <= 1'b1;
      repeat (BIT_CYCLES) @(posedge mclk);
   endtask
   // lsb first decode; a low stop bit is a break, skipped until high
   always begin
      wait (line_in === 1'b0);
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge mclk);
         b[i] = line_in;
      end
      repeat (BIT_CYCLES) @(posedge mclk);
      if (line_in) got.push_back(b);
      else wait (line_in === 1'b1);
   end
endmodule // lin_peer
`default_nettype wire

// ### testbench/lin_uart_command_sequencer_bench.sv
// self-checking bench for the lin/uart command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_regs.vh"
module lin_uart_command_sequencer_bench;
   localparam int BITC = 16;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   wire [7:0] rdata;
   wire rx_pin;
   wire tx_pin;
   logic [7:0] rv;
   logic [7:0] c;
   logic [7:0] d;
   logic [5:0] id;
   logic [7:0] dq[$];
   int failures = 0;
   int n_checks = 0;
   int k;
   int m;
   int n;
   always #5 mclk = ~mclk;
   lin_uart_command_sequencer #(.BIT_CYCLES(BITC), .TOUT_CYCLES(BITC * 175)) lin_uart_command_sequencer_i (
      .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin));
   lin_peer #(.BIT_CYCLES(BITC)) lin_peer_i (.mclk(mclk), .line_in(tx_pin), .line_out(rx_pin));
   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic wait_bit(input logic [2:0] a, input int b);
      int i;
      for (i = 0; i < 3000; i++) begin
         rd(a);
         if (rv[b] === 1'b1) break;
      end
      if (i == 3000) begin
         failures++;
         $display("unexpected timeout on address %0d bit %0d", a, b);
         finish_test;
      end
   endtask
   task automatic cmp_peer;
      while (dq.size() > 0) begin
         check("peer byte", dq.pop_front(), lin_peer_i.got.size() > 0 ? lin_peer_i.got.pop_front() : 8'hxx);
      end
      check("peer extra bytes", 8'h00, 8'(lin_peer_i.got.size()));
   endtask
   function automatic logic [7:0] pid_of(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction
   function automatic logic [7:0] cks(input logic [7:0] seed, input int from);
      int s;
      s = seed;
      for (int j = from; j < dq.size(); j++) begin
         s += dq[j];
         if (s > 255) s -= 255;
      end
      return ~s[7:0];
   endfunction
   initial begin
      void'($urandom(38));
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      rd(`A_CTRL);
      check("control", 8'h00, rv);
      rd(`A_ID);
      check("identifier", 8'h80, rv);
      rd(3'h7);
      check("unmapped", 8'h00, rv);
      // header then response: enhanced, legacy classic, reserved classic
      for (m = 0; m < 3; m++) begin
         id = (m == 2) ? 6'(`ID_CLASSIC + $urandom % 4) : 6'($urandom % 60);
         n = 1 + $urandom % 8;
         c = (m == 1) ? 8'h18 : 8'h08;
         wr(`A_STAT, 8'h07);
         wr(`A_ID, {2'h0, id});
         wr(`A_CTRL, c | 8'h01);
         wait_bit(`A_STAT, `F_IDOK);
         rd(`A_CTRL);
         check("control after header", c, rv);
         rd(`A_LEN);
         if (m == 1) check("legacy length", {4'h0, id[5] ? (id[4] ? 4'h8 : 4'h4) : 4'h2}, {4'h0, rv[3:0]});
         wr(`A_LEN, 8'(n << 4));
         wr(`A_SEL, 8'h00);
         dq = '{`SYNC_CHAR, pid_of(id)};
         for (k = 0; k < n; k++) begin
            dq.push_back(8'($urandom));
            wr(`A_DAT, dq[k + 2]);
         end
         dq.push_back(cks(m == 0 ? pid_of(id) : 8'h00, 2));
         wr(`A_CTRL, c | 8'h03);
         wait_bit(`A_STAT, `F_TXD);
         cmp_peer;
         rd(`A_CTRL);
         check("control after response", c, rv);
      end
      // receive response on a reserved identifier, then abort a second one
      wr(`A_STAT, 8'h07);
      wr(`A_CTRL, 8'h09);
      wait_bit(`A_STAT, `F_IDOK);
      wr(`A_ERR, 8'hFF);
      wr(`A_LEN, 8'h02);
      wr(`A_CTRL, 8'h0A);
      lin_peer_i.got.delete();
      dq = '{8'($urandom), 8'($urandom)};
      d = cks(8'h00, 0);
      for (k = 0; k < 3; k++) lin_peer_i.send(k < 2 ? dq[k] : d, 1'b1);
      wait_bit(`A_STAT, `F_RXD);
      rd(`A_ERR);
      check("error after response", 8'h00, rv);
      wr(`A_SEL, 8'h00);
      for (k = 0; k < 2; k++) begin
         rd(`A_DAT);
         check("response data", dq[k], rv);
      end
      wr(`A_CTRL, 8'h0A);
      wr(`A_CTRL, 8'h08);
      rd(`A_ERR);
      check("abort flag", 8'h20, rv);
      // header sent by a remote master, taken in the background
      wr(`A_STAT, 8'h07);
      id = 6'($urandom);
      lin_peer_i.send(8'h00, 1'b0);
      lin_peer_i.send(`SYNC_CHAR, 1'b1);
      lin_peer_i.send(pid_of(id), 1'b1);
      wait_bit(`A_STAT, `F_IDOK);
      rd(`A_ID);
      check("received identifier", pid_of(id), rv);
      rd(`A_ERR);
      check("error after header", 8'h20, rv);
      // uart full duplex, then receive only
      wr(`A_ERR, 8'hFF);
      wr(`A_CTRL, 8'h0F);
      rd(`A_LEN);
      check("uart length", 8'h00, rv);
      for (k = 0; k < 2; k++) begin
         dq = '{8'($urandom)};
         wr(`A_DAT, dq[0]);
         rd(`A_STAT);
         check("tx done while sending", 8'h00, {7'h0, rv[`F_TXD]});
         wait_bit(`A_STAT, `F_TXD);
         cmp_peer;
      end
      wr(`A_STAT, 8'h07);
      d = 8'($urandom);
      lin_peer_i.send(d, 1'b1);
      lin_peer_i.send(~d, 1'b1);
      wait_bit(`A_STAT, `F_RXD);
      rd(`A_ERR);
      check("overrun flag", 8'h01, {7'h0, rv[`E_OVR]});
      rd(`A_DAT);
      check("uart data", ~d, rv);
      rd(`A_STAT);
      check("rx done after read", 8'h00, {7'h0, rv[`F_RXD]});
      lin_peer_i.send(8'hA5, 1'b0);
      wait_bit(`A_ERR, `E_FRAMING_ERROR_FLAG);
      wr(`A_CTRL, 8'h0E);
      wr(`A_DAT, 8'h3C);
      repeat (12 * BITC) @(posedge mclk);
      check("bytes sent in receive only", 8'h00, 8'(lin_peer_i.got.size()));
      wr(`A_CTRL, 8'h00);
      rd(`A_CTRL);
      check("disabled control", 8'h00, rv);
      finish_test;
   end
endmodule // lin_uart_command_sequencer_bench
bind lin_uart_command_sequencer sequencer_checker #(.BIT_CYCLES(BIT_CYCLES)) sequencer_checker_i (
   .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
   .rd_en(rd_en), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin));
`default_nettype wire
